// >>> logic/monitor_regs_pkg.sv
// Purpose: Shared constants and types for the monitor status/control bank.
// Assumes: 125 MHz system clock; byte-wide register port.
// Notes:   Offsets are a compact local map, one byte address per register.
`default_nettype none
package monitor_regs_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_SCRATCH      = 8'h00;
  localparam logic [7:0] OFF_MAKER        = 8'h01;
  localparam logic [7:0] OFF_REVISION     = 8'h02;
  localparam logic [7:0] OFF_GEN_STATUS   = 8'h03;
  localparam logic [7:0] OFF_PIN_LEVEL    = 8'h04;
  localparam logic [7:0] OFF_UPPER_STATUS = 8'h05;
  localparam logic [7:0] OFF_LOWER_STATUS = 8'h06;
  localparam logic [7:0] OFF_GEN_CONFIG   = 8'h07;
  localparam logic [7:0] OFF_ANALOG_OUT   = 8'h08;
  localparam logic [7:0] OFF_PULLDOWN     = 8'h09;

  // ------------------------------------------------------------------
  // Reset values and writable-bit masks
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_SCRATCH     = 8'h00;
  localparam logic [7:0] RST_GEN_STATUS  = 8'h40;
  localparam logic [7:0] RST_GEN_CONFIG  = 8'h00;
  localparam logic [7:0] RST_ANALOG_OUT  = 8'h03;
  localparam logic [7:0] RST_PULLDOWN    = 8'hFF;
  localparam logic [7:0] RST_VIOLATION   = 8'h00;
  localparam logic [7:0] MASK_GEN_CONFIG = 8'h07;
  localparam logic [7:0] MASK_ANALOG_OUT = 8'h07;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int BIT_BUSY         = 7;
  localparam int BIT_PWR_PENDING  = 6;
  localparam int BIT_UPPER_SUM    = 2;
  localparam int BIT_LOWER_SUM    = 1;
  localparam int BIT_PIN_SUM      = 0;
  localparam int BIT_SOFT_RESET   = 7;
  localparam int BIT_TIMEOUT_DIS  = 2;
  localparam int BIT_FREEZE       = 1;
  localparam int BIT_RUN          = 0;
  localparam int BIT_GROUP_SEL    = 2;
  localparam int BIT_FORCED_LEVEL = 1;
  localparam int BIT_OUTPUTS_OFF  = 0;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int POWERUP_TIME_NS  = 1000;
  localparam int POWERUP_CYCLES   =
    (POWERUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUS_TIMEOUT_US   = 25;
  localparam int BUS_TIMEOUT_CYCLES =
    (BUS_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;

  // ------------------------------------------------------------------
  // Sizes and states
  // ------------------------------------------------------------------
  localparam int LIMIT_CHANNELS = 6;
  localparam int RESULT_W       = 12;
  localparam int OUTPUT_COUNT   = 12;
  localparam int CONTROL_INPUTS = 2;

  typedef enum logic [1:0] {
    PWR_WAIT = 2'b00,
    PWR_DONE = 2'b01
  } pwr_state_t;

  typedef enum logic [1:0] {
    TMO_IDLE  = 2'b00,
    TMO_COUNT = 2'b01,
    TMO_FIRED = 2'b11
  } tmo_state_t;

endpackage
`default_nettype wire

// >>> logic/limit_cmp_if.sv
// Purpose: Carries conversion results and thresholds to the bank, and flags back from it.
// Assumes: Channel index 0..5 stands for monitored channels 1,2,3,9,10,11.
// Notes:   Thresholds are supplied from outside this block.
`timescale 1ns/10ps
`default_nettype none
interface limit_cmp_if #(
  parameter int CHANNELS = 6,
  parameter int DATA_W   = 12
);
  logic                result_valid;
  logic [2:0]          result_chan;
  logic [DATA_W-1:0]   result_data;
  logic [DATA_W-1:0]   upper [CHANNELS];
  logic [DATA_W-1:0]   lower [CHANNELS];
  logic                clear;
  logic [CHANNELS-1:0] upper_flags;
  logic [CHANNELS-1:0] lower_flags;

  modport bank  (input  result_valid, result_chan, result_data, upper,
                 lower, clear, output upper_flags, lower_flags);
  modport owner (output result_valid, result_chan, result_data, upper,
                 lower, clear, input  upper_flags, lower_flags);
endinterface
`default_nettype wire

// >>> logic/limit_compare_bank.sv
// Purpose: Window comparator flags for the six limit-checked channels.
// Assumes: One result per strobe; channel index below CHANNELS.
// Notes:   Each flag reflects only the latest result of its channel.
`timescale 1ns/10ps
`default_nettype none
module limit_compare_bank #(
  parameter int CHANNELS = 6,
  parameter int DATA_W   = 12
) (
  // Clock and reset
  input wire logic  sys_clk,
  input wire logic  rst_n,
  // Comparator link
  limit_cmp_if.bank cmp
);

  initial begin
    if (CHANNELS < 1 || CHANNELS > 8) begin
      $error("CHANNELS must lie between 1 and 8");
    end
  end

  logic [CHANNELS-1:0] upper_q;
  logic [CHANNELS-1:0] lower_q;
  logic                hit;

  assign hit = cmp.result_valid && (32'(cmp.result_chan) < CHANNELS);

  // Upper is strictly above, lower includes equality.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || cmp.clear) begin
      upper_q <= '0;
      lower_q <= '0;
    end else if (hit) begin
      upper_q[cmp.result_chan] <=
        cmp.result_data > cmp.upper[cmp.result_chan];
      lower_q[cmp.result_chan] <=
        cmp.result_data <= cmp.lower[cmp.result_chan];
    end
  end

  assign cmp.upper_flags = upper_q;
  assign cmp.lower_flags = lower_q;

endmodule
`default_nettype wire

// >>> logic/monitor_status_control_regs.sv
// Purpose: Byte-wide status and control register bank of a monitor.
// Assumes: Register port strobes are synchronous, one cycle each.
// Notes:   Serial bus protocol, sequencing and data registers live elsewhere.
//
// What this block does
// - Scratch byte, resets to zero, read back only, no other effect.
// - Maker and revision codes are read-only constants.
// - Busy status bit follows converter activity.
// - General status resets to 0x40; pending flag clears after power-up.
// - Upper summary bit is set when any upper flag is set.
// - Lower summary bit is set when any lower flag is set.
// - Pin summary bit is set when any pin level bit is set.
// - Pin level status returns sampled level of each of eight pins.
// - Upper flag set when channel result exceeds upper threshold.
// - Lower flag set when channel result is at or below lower threshold.
// - Writing soft reset bit returns every register to power-on value except the sampled pin levels and busy bit.
// - While frozen, writes to lockable registers are ignored.
// - Continuous run starts only when run and freeze bits are both set.
// - Group select bit picks how outputs pair with control inputs.
// - Low control input forces its outputs to supply or ground per level bit.
// - Outputs-off bit puts all twelve analog outputs in high impedance.
// - Analog output config resets to 0x03.
// - Pulldown bit one turns pulldown off; register resets to 0xFF.
`timescale 1ns/10ps
`default_nettype none
module monitor_status_control_regs #(
  parameter logic [7:0]  MAKER_CODE         = 8'hA5, // Arbitrary value.
  parameter logic [7:0]  REVISION_CODE      = 8'h3C, // Arbitrary value.
  parameter int unsigned BUS_TIMEOUT_CYCLES =
    monitor_regs_pkg::BUS_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  // Bus watchdog
  input  wire logic        bus_active,
  output logic             bus_timeout_disable,
  output logic             bus_timeout_reset,
  // Converter
  input  wire logic        adc_converting,
  output logic             continuous_run,
  input  wire logic        result_valid,
  input  wire logic [2:0]  result_chan,
  input  wire logic [11:0] result_data,
  input  wire logic [71:0] upper_threshold,
  input  wire logic [71:0] lower_threshold,
  // General-purpose pins
  input  wire logic [7:0]  gpio_level,
  output logic [7:0]       pulldown_en,
  // Analog output control
  input  wire logic [1:0]  async_output_control_input_n,
  output logic [11:0]      analog_output_pin_force,
  output logic [11:0]      analog_output_pin_level,
  output logic [11:0]      analog_output_pin_hiz
);

  localparam int CH = monitor_regs_pkg::LIMIT_CHANNELS;
  localparam int DW = monitor_regs_pkg::RESULT_W;
  localparam int NO = monitor_regs_pkg::OUTPUT_COUNT;

  initial begin
    if (BUS_TIMEOUT_CYCLES < 2) begin
      $error("BUS_TIMEOUT_CYCLES must be at least 2");
    end
  end

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [7:0]                    scratch_q;
  logic [7:0]                    gen_config_q;
  logic [7:0]                    analog_out_q;
  logic [7:0]                    pulldown_q;
  logic [7:0]                    pin_level_q;
  logic                          busy_q;
  logic                          soft_rst;
  logic                          freeze;
  monitor_regs_pkg::pwr_state_t  pwr_state_q;
  logic [7:0]                    pwr_cnt_q;
  monitor_regs_pkg::tmo_state_t  tmo_state_q;
  logic [31:0]                   tmo_cnt_q;
  logic [7:0]                    gen_status;
  logic [7:0]                    upper_status;
  logic [7:0]                    lower_status;

  function automatic logic wr_hit(input logic [7:0] off);
    return reg_wr && (reg_addr == off);
  endfunction

  assign freeze   = gen_config_q[monitor_regs_pkg::BIT_FREEZE];
  // Soft reset wins over any other write in the same cycle.
  assign soft_rst = wr_hit(monitor_regs_pkg::OFF_GEN_CONFIG) &&
                    reg_wdata[monitor_regs_pkg::BIT_SOFT_RESET];

  // ------------------------------------------------------------------
  // Comparator bank
  // ------------------------------------------------------------------
  limit_cmp_if #(.CHANNELS(CH), .DATA_W(DW)) cmp ();

  assign cmp.result_valid = result_valid;
  assign cmp.result_chan  = result_chan;
  assign cmp.result_data  = result_data;
  assign cmp.clear        = soft_rst;

  for (genvar i = 0; i < CH; i++) begin : g_thr
    assign cmp.upper[i] = upper_threshold[i*DW +: DW];
    assign cmp.lower[i] = lower_threshold[i*DW +: DW];
  end

  limit_compare_bank #(.CHANNELS(CH), .DATA_W(DW)) u_cmp (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cmp     (cmp)
  );

  assign upper_status = {2'b00, cmp.upper_flags};
  assign lower_status = {2'b00, cmp.lower_flags};

  // ------------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      scratch_q <= monitor_regs_pkg::RST_SCRATCH;
    end else if (wr_hit(monitor_regs_pkg::OFF_SCRATCH)) begin
      scratch_q <= reg_wdata;
    end
  end

  // The config register stays writable while frozen so that run can stop.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      gen_config_q <= monitor_regs_pkg::RST_GEN_CONFIG;
    end else if (wr_hit(monitor_regs_pkg::OFF_GEN_CONFIG)) begin
      gen_config_q <= reg_wdata & monitor_regs_pkg::MASK_GEN_CONFIG;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      analog_out_q <= monitor_regs_pkg::RST_ANALOG_OUT;
    end else if (wr_hit(monitor_regs_pkg::OFF_ANALOG_OUT) && !freeze) begin
      analog_out_q <= reg_wdata & monitor_regs_pkg::MASK_ANALOG_OUT;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      pulldown_q <= monitor_regs_pkg::RST_PULLDOWN;
    end else if (wr_hit(monitor_regs_pkg::OFF_PULLDOWN) && !freeze) begin
      pulldown_q <= reg_wdata;
    end
  end

  // ------------------------------------------------------------------
  // Status sampling and power-up sequence
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_level_q <= 8'h00;
      busy_q      <= 1'b0;
    end else begin
      pin_level_q <= gpio_level;
      busy_q      <= adc_converting;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      pwr_state_q <= monitor_regs_pkg::PWR_WAIT;
      pwr_cnt_q   <= 8'h00;
    end else begin
      case (pwr_state_q)
        monitor_regs_pkg::PWR_WAIT: begin
          if (32'(pwr_cnt_q) == monitor_regs_pkg::POWERUP_CYCLES - 1) begin
            pwr_state_q <= monitor_regs_pkg::PWR_DONE;
          end else begin
            pwr_cnt_q <= pwr_cnt_q + 8'h01;
          end
        end
        monitor_regs_pkg::PWR_DONE: pwr_state_q <= monitor_regs_pkg::PWR_DONE;
        default: pwr_state_q <= monitor_regs_pkg::PWR_WAIT;
      endcase
    end
  end

  always_comb begin
    gen_status = 8'h00;
    gen_status[monitor_regs_pkg::BIT_BUSY] = busy_q;
    gen_status[monitor_regs_pkg::BIT_PWR_PENDING] =
      (pwr_state_q != monitor_regs_pkg::PWR_DONE);
    gen_status[monitor_regs_pkg::BIT_UPPER_SUM] = |upper_status;
    gen_status[monitor_regs_pkg::BIT_LOWER_SUM] = |lower_status;
    gen_status[monitor_regs_pkg::BIT_PIN_SUM]   = |pin_level_q;
  end

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          monitor_regs_pkg::OFF_SCRATCH:      reg_rdata <= scratch_q;
          monitor_regs_pkg::OFF_MAKER:        reg_rdata <= MAKER_CODE;
          monitor_regs_pkg::OFF_REVISION:     reg_rdata <= REVISION_CODE;
          monitor_regs_pkg::OFF_GEN_STATUS:   reg_rdata <= gen_status;
          monitor_regs_pkg::OFF_PIN_LEVEL:    reg_rdata <= pin_level_q;
          monitor_regs_pkg::OFF_UPPER_STATUS: reg_rdata <= upper_status;
          monitor_regs_pkg::OFF_LOWER_STATUS: reg_rdata <= lower_status;
          monitor_regs_pkg::OFF_GEN_CONFIG:   reg_rdata <= gen_config_q;
          monitor_regs_pkg::OFF_ANALOG_OUT:   reg_rdata <= analog_out_q;
          monitor_regs_pkg::OFF_PULLDOWN:     reg_rdata <= pulldown_q;
          default:                            reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Bus watchdog and conversion run
  // ------------------------------------------------------------------
  assign bus_timeout_disable = gen_config_q[monitor_regs_pkg::BIT_TIMEOUT_DIS];

  // One reset pulse per stall; the bus must go idle before another.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tmo_state_q       <= monitor_regs_pkg::TMO_IDLE;
      tmo_cnt_q         <= 32'h0000_0000;
      bus_timeout_reset <= 1'b0;
    end else begin
      bus_timeout_reset <= 1'b0;
      case (tmo_state_q)
        monitor_regs_pkg::TMO_IDLE: begin
          tmo_cnt_q <= 32'h0000_0000;
          if (bus_active && !bus_timeout_disable) begin
            tmo_state_q <= monitor_regs_pkg::TMO_COUNT;
          end
        end
        monitor_regs_pkg::TMO_COUNT: begin
          if (!bus_active || bus_timeout_disable) begin
            tmo_state_q <= monitor_regs_pkg::TMO_IDLE;
          end else if (tmo_cnt_q == BUS_TIMEOUT_CYCLES - 2) begin
            tmo_state_q       <= monitor_regs_pkg::TMO_FIRED;
            bus_timeout_reset <= 1'b1;
          end else begin
            tmo_cnt_q <= tmo_cnt_q + 32'h0000_0001;
          end
        end
        monitor_regs_pkg::TMO_FIRED: begin
          if (!bus_active) begin
            tmo_state_q <= monitor_regs_pkg::TMO_IDLE;
          end
        end
        default: tmo_state_q <= monitor_regs_pkg::TMO_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      continuous_run <= 1'b0;
    end else begin
      continuous_run <= gen_config_q[monitor_regs_pkg::BIT_RUN] &&
                        freeze;
    end
  end

  // ------------------------------------------------------------------
  // Analog output control
  // ------------------------------------------------------------------
  // Split mode: first control input serves outputs 1-6, second 7-12.
  function automatic logic group_ctrl_n(input int idx, input logic output_group_select,
                                        input logic [1:0] ctl_n);
    return output_group_select ? ctl_n[0] : ctl_n[idx / (NO / 2)];
  endfunction

  assign pulldown_en = ~pulldown_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      analog_output_pin_force <= '0;
      analog_output_pin_level <= '0;
      analog_output_pin_hiz   <= '1;
    end else begin
      for (int i = 0; i < NO; i++) begin
        analog_output_pin_force[i] <= !group_ctrl_n(i,
          analog_out_q[monitor_regs_pkg::BIT_GROUP_SEL],
          async_output_control_input_n);
        analog_output_pin_level[i] <=
          analog_out_q[monitor_regs_pkg::BIT_FORCED_LEVEL];
        analog_output_pin_hiz[i] <=
          analog_out_q[monitor_regs_pkg::BIT_OUTPUTS_OFF];
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_scratch_readback;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_hit(monitor_regs_pkg::OFF_SCRATCH) ##1 !reg_wr ##1
      (reg_rd && reg_addr == monitor_regs_pkg::OFF_SCRATCH && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_scratch_readback: assert property (p_scratch_readback)
    else $error("scratch read back differs from written value");

  property p_maker_fixed;
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == monitor_regs_pkg::OFF_MAKER
      |=> reg_rvalid && reg_rdata == MAKER_CODE;
  endproperty
  a_maker_fixed: assert property (p_maker_fixed)
    else $error("maker code read wrong");

  property p_pwr_pending;
    @(posedge sys_clk) disable iff (!rst_n)
    soft_rst |=> gen_status[monitor_regs_pkg::BIT_PWR_PENDING]
      ##125 !gen_status[monitor_regs_pkg::BIT_PWR_PENDING];
  endproperty
  a_pwr_pending: assert property (p_pwr_pending)
    else $error("power-up pending flag timing wrong");

  property p_upper_summary;
    @(posedge sys_clk) disable iff (!rst_n)
    result_valid && result_chan == 3'h0 && !soft_rst &&
      result_data > upper_threshold[DW-1:0]
      |=> gen_status[monitor_regs_pkg::BIT_UPPER_SUM];
  endproperty
  a_upper_summary: assert property (p_upper_summary)
    else $error("upper summary not set after violation");

  property p_freeze_holds;
    @(posedge sys_clk) disable iff (!rst_n)
    freeze && !soft_rst && wr_hit(monitor_regs_pkg::OFF_PULLDOWN)
      |=> $stable(pulldown_q);
  endproperty
  a_freeze_holds: assert property (p_freeze_holds)
    else $error("frozen register changed on write");

  property p_run_needs_freeze;
    @(posedge sys_clk) disable iff (!rst_n)
    continuous_run |-> $past(freeze) &&
      $past(gen_config_q[monitor_regs_pkg::BIT_RUN]);
  endproperty
  a_run_needs_freeze: assert property (p_run_needs_freeze)
    else $error("run started without freeze and run bits");

  property p_soft_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    soft_rst |=> scratch_q == 8'h00 && pulldown_q == 8'hFF &&
      analog_out_q == 8'h03 ##1 (&analog_output_pin_hiz);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset left a register unrestored");

  property p_timeout_off;
    @(posedge sys_clk) disable iff (!rst_n)
    bus_timeout_disable [*2] |-> !bus_timeout_reset;
  endproperty
  a_timeout_off: assert property (p_timeout_off)
    else $error("bus reset issued while timeout disabled");

endmodule
`default_nettype wire

// >>> test/host_port_model.sv
// Purpose: Host model that drives the byte register port of the bank.
// Assumes: Strobes are one-cycle pulses launched at the falling edge.
// Notes:   The bench calls wr and rd through this instance.
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  // Clock
  input  wire logic       sys_clk,
  // Register port
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Released data is inverted so that a stale byte is never relied on.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_monitor_status_control_regs.sv
// Purpose: Self-checking bench for the monitor register bank.
// Assumes: Host model drives the register port at falling edges.
// Notes:   Bus timeout is cut to 16 cycles to keep the run short.
`timescale 1ns/10ps
`default_nettype none
module tb_monitor_status_control_regs;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, gpio_level, pulldown_en;
  logic        reg_wr, reg_rd, reg_rvalid, bus_active, tmo_dis, tmo_rst;
  logic        adc_converting, continuous_run, result_valid, seen;
  logic [2:0]  result_chan;
  logic [11:0] result_data, pin_force, pin_level, pin_hiz;
  logic [1:0]  ctl_n;
  int          n_mismatch, n_tests, i;
  always #4 sys_clk = ~sys_clk;
  host_port_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  monitor_status_control_regs #(.BUS_TIMEOUT_CYCLES(16)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .bus_active(bus_active), .bus_timeout_disable(tmo_dis),
    .bus_timeout_reset(tmo_rst), .adc_converting(adc_converting),
    .continuous_run(continuous_run), .result_valid(result_valid),
    .result_chan(result_chan), .result_data(result_data),
    .upper_threshold({6{12'h800}}), .lower_threshold({6{12'h100}}),
    .gpio_level(gpio_level), .pulldown_en(pulldown_en),
    .async_output_control_input_n(ctl_n),
    .analog_output_pin_force(pin_force),
    .analog_output_pin_level(pin_level), .analog_output_pin_hiz(pin_hiz));
  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [11:0] got,
                       input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host_u.rd(a, d, ok);
    check($sformatf("rvalid %h", a), {11'h000, ok}, 12'h001);
    check($sformatf("rdata %h", a), {4'h0, d}, {4'h0, exp});
  endtask
  task automatic res(input logic [2:0] c, input logic [11:0] d);
    @(negedge sys_clk);
    result_chan = c;
    result_data = d;
    result_valid = 1'b1;
    @(negedge sys_clk);
    result_valid = 1'b0;
  endtask
  task automatic watch(input logic exp);
    seen = 1'b0;
    for (i = 0; i < 40 && seen !== 1'b1; i++) begin
      @(negedge sys_clk);
      seen = tmo_rst;
    end
    bus_active = 1'b0;
    check("bus timeout pulse", {11'h000, seen}, {11'h000, exp});
  endtask
  initial begin
    {n_mismatch, n_tests, bus_active, adc_converting} = '0;
    {result_valid, result_chan, result_data, gpio_level} = '0;
    ctl_n = 2'b11;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    rchk(8'h00, 8'h00);
    rchk(8'h03, 8'h40);
    rchk(8'h07, 8'h00);
    rchk(8'h08, 8'h03);
    rchk(8'h09, 8'hFF);
    rchk(8'h05, 8'h00);
    rchk(8'h06, 8'h00);
    rchk(8'h20, 8'h00);
    check("pulldown", {4'h0, pulldown_en}, 12'h000);
    check("hiz", pin_hiz, 12'hFFF);
    host_u.wr(8'h00, 8'h5A);
    rchk(8'h00, 8'h5A);
    host_u.wr(8'h01, 8'hFF);
    rchk(8'h01, 8'hA5);
    rchk(8'h02, 8'h3C);
    repeat (130) @(negedge sys_clk);
    rchk(8'h03, 8'h00);
    gpio_level = 8'h81;
    adc_converting = 1'b1;
    res(3'd0, 12'h801);
    res(3'd1, 12'h100);
    res(3'd2, 12'h800);
    res(3'd6, 12'hFFF);
    rchk(8'h04, 8'h81);
    rchk(8'h05, 8'h01);
    rchk(8'h06, 8'h02);
    rchk(8'h03, 8'h87);
    res(3'd0, 12'h500);
    rchk(8'h05, 8'h00);
    rchk(8'h03, 8'h83);
    bus_active = 1'b1;
    watch(1'b1);
    if (seen !== 1'b1)
      final_report();
    host_u.wr(8'h07, 8'h7F);
    rchk(8'h07, 8'h07);
    check("timeout off", {11'h000, tmo_dis}, 12'h001);
    check("run", {11'h000, continuous_run}, 12'h001);
    bus_active = 1'b1;
    watch(1'b0);
    host_u.wr(8'h08, 8'h00);
    rchk(8'h08, 8'h03);
    host_u.wr(8'h09, 8'h00);
    rchk(8'h09, 8'hFF);
    host_u.wr(8'h07, 8'h01);
    repeat (2) @(negedge sys_clk);
    check("run", {11'h000, continuous_run}, 12'h000);
    host_u.wr(8'h08, 8'hFE);
    rchk(8'h08, 8'h06);
    ctl_n = 2'b10;
    repeat (2) @(negedge sys_clk);
    check("force", pin_force, 12'hFFF);
    check("level", pin_level, 12'hFFF);
    check("hiz", pin_hiz, 12'h000);
    ctl_n = 2'b01;
    host_u.wr(8'h08, 8'h00);
    repeat (2) @(negedge sys_clk);
    check("force", pin_force, 12'hFC0);
    check("level", pin_level, 12'h000);
    host_u.wr(8'h09, 8'h0F);
    repeat (2) @(negedge sys_clk);
    check("pulldown", {4'h0, pulldown_en}, 12'h0F0);
    host_u.wr(8'h07, 8'h81);
    rchk(8'h00, 8'h00);
    rchk(8'h07, 8'h00);
    rchk(8'h08, 8'h03);
    rchk(8'h09, 8'hFF);
    rchk(8'h03, 8'hC1);
    repeat (130) @(negedge sys_clk);
    rchk(8'h03, 8'h81);
    final_report();
  end
endmodule
`default_nettype wire
